// ### src/jesd_sync_params.svh
`ifndef JESD_SYNC_PARAMS_SVH
`define JESD_SYNC_PARAMS_SVH

// ----------------------------------------------------------------------
// Link geometry.
// ----------------------------------------------------------------------
`define NUM_LANES 16
`define LMFC_CYCLES 5'd31
`define LMFC_W 5
`define ILAS_MULTIFRAMES 2'd3
`define ILAS_CNT_W 2

// ----------------------------------------------------------------------
// Sync source select encodings and idle levels.
// ----------------------------------------------------------------------
`define SYNC_SEL_SINGLE_ENDED 1'b0
`define SYNC_SEL_TIMESTAMP 1'b1
`define SYNC_IDLE_LEVEL 1'b1
`define READ_PIN_IDLE_LEVEL 1'b0

`endif

// ### src/jesd_sync_pkg.sv
package jesd_sync_pkg;

  // Link initialization phases seen by the lanes.
  typedef enum logic [2:0] {
    LS_IDLE,
    LS_CGS,
    LS_ILAS_WAIT,
    LS_ILAS,
    LS_DATA,
    LS_RUN64
  } linkState_t;

endpackage

// ### src/sync_req_if.sv
`timescale 1ns/100ps

// Conditioned sync and reference events, all on core_clk.
interface sync_req_if;
  logic syncReqN;
  logic syncRise;
  logic syncFall;
  logic sysrefRise;

  modport src (
    output syncReqN,
    output syncRise,
    output syncFall,
    output sysrefRise
  );

  modport dst (
    input syncReqN,
    input syncRise,
    input syncFall,
    input sysrefRise
  );
endinterface

// ### src/sync_pin_conditioner.sv
`timescale 1ns/100ps
`include "jesd_sync_params.svh"

module sync_pin_conditioner (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic nrst,
  // Raw pins, asynchronous to core_clk.
  input wire logic singleEndedSyncPinN,
  input wire logic timestampDiffPair,
  input wire logic sysrefPin,
  // Static configuration.
  input wire logic syncSourceSelect,
  input wire logic timestampReceiverEnable,
  // Conditioned events.
  sync_req_if.src req
);

  logic [2:0] pinMeta_r;
  logic [2:0] pinSync_r;
  logic sysrefDly_r;
  logic tsLevel;
  logic syncSel_nxt;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  // ----------------------------------------------------------------------
  // Two-stage synchronisers; only the second stage feeds logic.
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      // The reference stage resets to its idle low level, so reset release gives no false edge.
      pinMeta_r <= 3'h3;
      pinSync_r <= 3'h3;
    end else begin
      pinMeta_r <= {sysrefPin, timestampDiffPair, singleEndedSyncPinN};
      pinSync_r <= pinMeta_r;
    end
  end

  // A disabled timestamp receiver reads as the idle high level, so it can never request.
  assign tsLevel = timestampReceiverEnable ? pinSync_r[1] : `SYNC_IDLE_LEVEL; // RULE_09

  // Both sources are active low, so the pair feeds the request without inversion.
  assign syncSel_nxt = (syncSourceSelect == `SYNC_SEL_TIMESTAMP) ? tsLevel // RULE_06 RULE_08
                                                                 : pinSync_r[0]; // RULE_02

  // ----------------------------------------------------------------------
  // Registered request level and its edges.
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      req.syncReqN <= `SYNC_IDLE_LEVEL;
      req.syncRise <= 1'b0;
      req.syncFall <= 1'b0;
    end else begin
      req.syncReqN <= syncSel_nxt;
      req.syncRise <= syncSel_nxt & ~req.syncReqN;
      req.syncFall <= ~syncSel_nxt & req.syncReqN;
    end
  end

  // Reference edge detect; one pulse per rising edge of the reference.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sysrefDly_r <= 1'b0;
      req.sysrefRise <= 1'b0;
    end else begin
      sysrefDly_r <= pinSync_r[2];
      req.sysrefRise <= pinSync_r[2] & ~sysrefDly_r; // RULE_07
    end
  end

  AST_SE_SOURCE: assert property ( // RULE_02
    (syncSourceSelect == `SYNC_SEL_SINGLE_ENDED) && !pinSync_r[0] |=> !req.syncReqN
  ) else $error("Single-ended sync low did not reach the request.");

  AST_TS_SOURCE: assert property ( // RULE_06
    (syncSourceSelect == `SYNC_SEL_TIMESTAMP) && timestampReceiverEnable && !pinSync_r[1]
      |=> !req.syncReqN
  ) else $error("Timestamp pair low did not reach the request.");

  AST_TS_GATED: assert property ( // RULE_09
    (syncSourceSelect == `SYNC_SEL_TIMESTAMP) && !timestampReceiverEnable |=> req.syncReqN
  ) else $error("Disabled timestamp receiver produced a request.");

endmodule

// ### src/jesd_sync_link_init.sv
`timescale 1ns/100ps
`include "jesd_sync_params.svh"

// What this block does
// RULE_01 - Data output pin is driven only while a serial register read runs.
// RULE_02 - Select 0 in 8b/10b uses the active-low single-ended pin as request.
// RULE_03 - 64b/66b ignores sync for link start; sync may pulse oscillator alignment.
// RULE_04 - Sync low in 8b/10b starts code group synchronisation on the lanes.
// RULE_05 - Receiver raises sync after synchronisation; the rise starts lane alignment.
// RULE_06 - Select 1 takes sync from the differential timestamp pair instead.
// RULE_07 - Reference input aligns the multiframe timing for deterministic latency.
// RULE_08 - Sync on the timestamp pair is active low, like the single-ended pin.
// RULE_09 - Timestamp pair is ignored unless its receiver enable is set.
// RULE_10 - While sync stays low, enabled lanes send sync characters and no samples.
module jesd_sync_link_init (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic nrst,
  // Link pins, asynchronous to core_clk.
  input wire logic singleEndedSyncPinN,
  input wire logic timestampDiffPair,
  input wire logic sysrefPin,
  // Static configuration.
  input wire logic syncSourceSelect,
  input wire logic timestampReceiverEnable,
  input wire logic mode64b66b,
  input wire logic [`NUM_LANES-1:0] laneEnable,
  // Serial interface read path.
  input wire logic spiReadActive,
  input wire logic spiReadBit,
  output logic spiReadDataPinOut,
  output logic spiReadDataPinOe,
  // Lane control.
  output logic [`NUM_LANES-1:0] laneSendCgs,
  output logic [`NUM_LANES-1:0] laneSendIlas,
  output logic [`NUM_LANES-1:0] laneSendData,
  output jesd_sync_pkg::linkState_t linkState,
  // Timing events.
  output logic lmfcTick,
  output logic ncoSyncPulse
);
  import jesd_sync_pkg::*;

  sync_req_if syncIf ();

  linkState_t linkState_r;
  logic [`LMFC_W-1:0] lmfcCnt_r;
  logic [`ILAS_CNT_W-1:0] ilasCnt_r;
  logic lmfcLast;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  // Lanes carry samples in the data phase of either encoding.
  function automatic logic sendsData(input linkState_t s);
    return (s == LS_DATA) || (s == LS_RUN64);
  endfunction

  // Alignment characters go out while waiting for and during the alignment phase.
  function automatic logic sendsIlas(input linkState_t s);
    return (s == LS_ILAS_WAIT) || (s == LS_ILAS);
  endfunction

  // ----------------------------------------------------------------------
  // Pin conditioning and source selection.
  // ----------------------------------------------------------------------
  sync_pin_conditioner conditioner (
    .core_clk(core_clk),
    .nrst(nrst),
    .singleEndedSyncPinN(singleEndedSyncPinN),
    .timestampDiffPair(timestampDiffPair),
    .sysrefPin(sysrefPin),
    .syncSourceSelect(syncSourceSelect),
    .timestampReceiverEnable(timestampReceiverEnable),
    .req(syncIf.src)
  );

  // ----------------------------------------------------------------------
  // Multiframe timing.
  // ----------------------------------------------------------------------
  assign lmfcLast = (lmfcCnt_r == `LMFC_CYCLES);

  // The reference edge restarts the multiframe count, so every device that shares the
  // reference puts its boundaries on the same edge.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      lmfcCnt_r <= '0;
    end else if (syncIf.sysrefRise) begin
      lmfcCnt_r <= '0; // RULE_07
    end else if (lmfcLast) begin
      lmfcCnt_r <= '0;
    end else begin
      lmfcCnt_r <= lmfcCnt_r + `LMFC_W'(1);
    end
  end

  // Boundary marker is high in the cycle in which the count stands at zero.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      lmfcTick <= 1'b0;
    end else begin
      lmfcTick <= syncIf.sysrefRise | lmfcLast; // RULE_07
    end
  end

  // ----------------------------------------------------------------------
  // Link initialization sequence.
  // ----------------------------------------------------------------------
  // Sync low always wins and restarts synchronisation, so a receiver that loses lock
  // can pull the link back from any phase; the 64b/66b mode overrides it entirely.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      linkState_r <= LS_IDLE;
    end else if (mode64b66b) begin
      linkState_r <= LS_RUN64; // RULE_03
    end else if (!syncIf.syncReqN) begin
      linkState_r <= LS_CGS; // RULE_04
    end else begin
      case (linkState_r)
        LS_CGS: begin
          if (syncIf.syncRise) begin
            linkState_r <= LS_ILAS_WAIT; // RULE_05
          end
        end
        LS_ILAS_WAIT: begin
          if (lmfcLast) begin
            linkState_r <= LS_ILAS;
          end
        end
        LS_ILAS: begin
          if (lmfcLast && (ilasCnt_r == `ILAS_MULTIFRAMES)) begin
            linkState_r <= LS_DATA;
          end
        end
        LS_DATA: begin
          linkState_r <= LS_DATA;
        end
        LS_RUN64: begin
          linkState_r <= LS_IDLE;
        end
        default: begin
          linkState_r <= LS_IDLE;
        end
      endcase
    end
  end

  // Counts the multiframes of the alignment sequence.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ilasCnt_r <= '0;
    end else if (linkState_r != LS_ILAS) begin
      ilasCnt_r <= '0;
    end else if (lmfcLast) begin
      ilasCnt_r <= ilasCnt_r + `ILAS_CNT_W'(1);
    end
  end

  assign linkState = linkState_r;

  // In 64b/66b the falling sync edge only aligns the oscillators.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ncoSyncPulse <= 1'b0;
    end else begin
      ncoSyncPulse <= mode64b66b & syncIf.syncFall; // RULE_03
    end
  end

  // ----------------------------------------------------------------------
  // Per-lane content selection.
  // ----------------------------------------------------------------------
  for (genvar lane = 0; lane < `NUM_LANES; lane++) begin : gLane
    always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
        laneSendCgs[lane] <= 1'b0;
        laneSendIlas[lane] <= 1'b0;
        laneSendData[lane] <= 1'b0;
      end else begin
        laneSendCgs[lane] <= laneEnable[lane] & (linkState_r == LS_CGS); // RULE_10
        laneSendIlas[lane] <= laneEnable[lane] & sendsIlas(linkState_r);
        laneSendData[lane] <= laneEnable[lane] & sendsData(linkState_r);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Serial interface data output.
  // ----------------------------------------------------------------------
  // The pin is released outside reads so it can share a line with other devices.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      spiReadDataPinOe <= 1'b0;
      spiReadDataPinOut <= `READ_PIN_IDLE_LEVEL;
    end else begin
      spiReadDataPinOe <= spiReadActive; // RULE_01
      spiReadDataPinOut <= spiReadActive ? spiReadBit : `READ_PIN_IDLE_LEVEL;
    end
  end

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  AST_READ_PIN_RELEASED: assert property ( // RULE_01
    !spiReadActive |=> !spiReadDataPinOe
  ) else $error("Read data pin driven outside a read.");

  AST_READ_PIN_DATA: assert property ( // RULE_01
    spiReadActive |=> spiReadDataPinOe && (spiReadDataPinOut == $past(spiReadBit))
  ) else $error("Read data pin not carrying read data.");

  AST_SYNC_LOW_CGS: assert property ( // RULE_04
    !mode64b66b && !syncIf.syncReqN |=> linkState_r == LS_CGS
  ) else $error("Sync low did not start code group synchronisation.");

  // A fresh sync request may legally pull the link back to synchronisation before the boundary.
  AST_RISE_ILAS: assert property ( // RULE_05
    !mode64b66b && (linkState_r == LS_CGS) && syncIf.syncRise
      |=> (linkState_r == LS_ILAS_WAIT) ##[1:32] (linkState_r inside {LS_ILAS, LS_CGS})
  ) else $error("Sync rise did not lead to lane alignment or a restart in one multiframe.");

  AST_64B_NO_INIT: assert property ( // RULE_03
    mode64b66b |=> (linkState_r == LS_RUN64) && !(|laneSendCgs)
  ) else $error("Sync used for link start in 64b/66b mode.");

  AST_SYSREF_ALIGN: assert property ( // RULE_07
    syncIf.sysrefRise |=> lmfcTick && (lmfcCnt_r == '0)
  ) else $error("Reference edge did not realign multiframe timing.");

  AST_CGS_LANES: assert property ( // RULE_10
    linkState_r == LS_CGS |=> (laneSendCgs == $past(laneEnable)) && (laneSendData == '0)
  ) else $error("Lanes not sending only sync characters during synchronisation.");

endmodule

// ### test/jesd_rx_model.sv
`timescale 1ns/100ps
`include "jesd_sync_params.svh"

// Far-end receiver: requests sync, waits for sync characters, then releases.
module jesd_rx_model (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic nrst,
  // Bench command.
  input wire logic restart,
  // Lane content seen at the far end.
  input wire logic [`NUM_LANES-1:0] laneEnable,
  input wire logic [`NUM_LANES-1:0] laneSendCgs,
  // Active-low sync request.
  output logic syncN
);
  int seen;
  int need;

  // A random settle time makes the receiver answer promptly or slowly.
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      syncN <= 1'b1;
      seen <= 0;
    end else if (restart) begin
      syncN <= #2 1'b0;
      seen <= 0;
      need <= 2 + $urandom_range(0, 6);
    end else if (!syncN && laneSendCgs === laneEnable) begin
      seen <= seen + 1;
      if (seen >= need) begin
        syncN <= #2 1'b1;
      end
    end
  end
endmodule

// ### test/jesd_sync_link_init_tb.sv
`timescale 1ns/100ps
`include "jesd_sync_params.svh"

`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin errCount++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end

module jesd_sync_link_init_tb;
  import jesd_sync_pkg::*;
  logic core_clk, nrst, sysrefPin, syncSourceSelect, timestampReceiverEnable;
  logic mode64b66b, spiReadActive, spiReadBit, restart, rxSyncN, dOut, dOe, lmfcTick, nco;
  logic [`NUM_LANES-1:0] laneEnable, cgs, ilas, dat;
  linkState_t linkState;
  int errCount = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;
  logic pa, pb;

  // The unselected sync input is held low, so a leak would start a link.
  jesd_sync_link_init i_dut (.core_clk(core_clk), .nrst(nrst),
    .singleEndedSyncPinN(syncSourceSelect ? 1'b0 : rxSyncN),
    .timestampDiffPair(syncSourceSelect ? rxSyncN : 1'b0), .sysrefPin(sysrefPin),
    .syncSourceSelect(syncSourceSelect), .timestampReceiverEnable(timestampReceiverEnable),
    .mode64b66b(mode64b66b), .laneEnable(laneEnable), .spiReadActive(spiReadActive),
    .spiReadBit(spiReadBit), .spiReadDataPinOut(dOut), .spiReadDataPinOe(dOe),
    .laneSendCgs(cgs), .laneSendIlas(ilas), .laneSendData(dat), .linkState(linkState),
    .lmfcTick(lmfcTick), .ncoSyncPulse(nco));

  jesd_rx_model i_rx (.core_clk(core_clk), .nrst(nrst), .restart(restart),
    .laneEnable(laneEnable), .laneSendCgs(cgs), .syncN(rxSyncN));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Cut a hang short well beyond the expected run length.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errCount++;
      close_out();
    end
  end

  task automatic step(input int k);
    repeat (k) @(posedge core_clk);
    #2;
  endtask

  // Configuration is static, so it only changes under reset.
  task automatic rst_cfg(input logic sel, input logic en, input logic m64);
    nrst = 1'b0;
    syncSourceSelect = sel;
    timestampReceiverEnable = en;
    mode64b66b = m64;
    laneEnable = 16'($urandom()) | 16'h0001;
    step(3);
    nrst = 1'b1;
  endtask

  task automatic kick();
    restart = 1'b1;
    step(1);
    restart = 1'b0;
  endtask

  task automatic wait_st(input linkState_t s, input int lim);
    n = 0;
    while (linkState !== s && n < lim) begin
      step(1);
      n++;
    end
    `CHK("linkState", s, linkState)
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(74848));
    {nrst, sysrefPin, spiReadActive, spiReadBit, restart} = '0;
    rst_cfg(1'b0, 1'b1, 1'b0);
    // Reference rise fixes the multiframe phase: tick at 4 edges, then every 32.
    sysrefPin = 1'b1;
    step(4);
    `CHK("lmfcTick", 1'b1, lmfcTick)
    for (int i = 1; i <= 32; i++) begin
      step(1);
      `CHK("lmfcTick", i == 32, lmfcTick)
    end
    sysrefPin = 1'b0;
    kick();
    wait_st(LS_CGS, 10);
    step(1);
    `CHK("laneSendCgs", laneEnable, cgs)
    `CHK("laneSendData", 16'h0000, dat)
    wait_st(LS_ILAS_WAIT, 60);
    wait_st(LS_ILAS, 40);
    step(1);
    `CHK("laneSendIlas", laneEnable, ilas)
    wait_st(LS_DATA, 140);
    step(1);
    `CHK("laneSendData", laneEnable, dat)
    $display("test single_ended done");
    rst_cfg(1'b1, 1'b1, 1'b0);
    kick();
    wait_st(LS_CGS, 10);
    wait_st(LS_ILAS_WAIT, 60);
    kick();
    wait_st(LS_CGS, 10);
    $display("test timestamp_pair done");
    rst_cfg(1'b1, 1'b0, 1'b0);
    kick();
    for (int i = 0; i < 12; i++) begin
      step(1);
      `CHK("linkState", LS_IDLE, linkState)
    end
    $display("test pair_disabled done");
    rst_cfg(1'b0, 1'b1, 1'b1);
    step(2);
    `CHK("linkState", LS_RUN64, linkState)
    kick();
    n = 0;
    for (int i = 0; i < 10; i++) begin
      step(1);
      n += int'(nco === 1'b1);
      `CHK("linkState", LS_RUN64, linkState)
    end
    `CHK("ncoSyncPulse count", 1, n)
    `CHK("laneSendData", laneEnable, dat)
    $display("test wide_code done");
    // Random read traffic: the pin follows one cycle later, else released.
    for (int i = 0; i < 24; i++) begin
      pa = 1'($urandom());
      pb = 1'($urandom());
      spiReadActive = pa;
      spiReadBit = pb;
      step(1);
      `CHK("spiReadDataPinOe", pa, dOe)
      `CHK("spiReadDataPinOut", pa & pb, dOut)
    end
    $display("test read_pin done");
    close_out();
  end
endmodule
